// ==== verilog/module_power_on_sequencer.sv ====
// power-on sequencer: toggle pin in, power monitor and software ready out
// assumes toggle and battery detect are asynchronous pins, host open-collector
//
// How it works
// - after a start the block boots and refuses all host access meanwhile.
// - the block is never operational sooner than 20 s after the toggle went low.
// - software ready appears on shared pin eight unless that pin is reassigned.
// - software ready is high only when fully up; the host takes it as go-ahead.
// - power monitor rises only after every pad has been configured.
// - power monitor rises about 21 s and software ready about 28 s after start.
// - a toggle tied low starts the sequence as soon as battery is present.
// - the toggle is pulled up inside; the host only pulls low or releases.
`default_nettype none

module module_power_on_sequencer
  import power_seq_pkg::*;
#(
  parameter longint unsigned PRESS_CYCLES   = PRESS_CYC,
  parameter longint unsigned MONITOR_CYCLES = MONITOR_CYC,
  parameter longint unsigned READY_CYCLES   = READY_CYC
) (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic batteryPresent,
  input  wire logic powerToggle_n,
  output logic      powerTogglePullUp,
  input  wire logic sharedPinFn,
  input  wire logic sharedPinGpioOut,
  output logic      sharedPin8Out,
  output logic      sharedPin8Oe,
  output logic      powerMonitor,
  output logic      auxSupplyOut,
  output logic      hostAccessOk,
  output seqStatus_t status
);

  localparam logic [CNT_W-1:0] PRESS_LIM   = CNT_W'(PRESS_CYCLES);
  localparam logic [CNT_W-1:0] MONITOR_LIM = CNT_W'(MONITOR_CYCLES);
  localparam logic [CNT_W-1:0] READY_LIM   = CNT_W'(READY_CYCLES);
  // minimum operational time, scaled with the ready count so short test counts keep the ratio
  localparam logic [CNT_W-1:0] OPER_LIM    = CNT_W'(READY_CYCLES * OPER_MIN_S / READY_TYP_S);

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  logic toggleMeta_r;
  logic toggleSync_r;
  logic battMeta_r;
  logic battSync_r;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      toggleMeta_r <= 1'b1;
      toggleSync_r <= 1'b1;
    end else begin
      toggleMeta_r <= powerToggle_n;
      toggleSync_r <= toggleMeta_r;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      battMeta_r <= 1'b0;
      battSync_r <= 1'b0;
    end else begin
      battMeta_r <= batteryPresent;
      battSync_r <= battMeta_r;
    end
  end

  // internal pull-up is always on; the host side is open-collector only
  assign powerTogglePullUp = 1'b1;

  // ==========================================================================
  // press timing and boot timing
  // ==========================================================================
  seqState_t state_r;
  seqState_t state_nxt;
  logic [CNT_W-1:0] pressCnt;
  logic [CNT_W-1:0] bootCnt;
  logic pressClear;
  logic bootClear;
  logic pressLong;
  logic tiedLow_r;
  logic battPrev_r;

  assign pressClear = toggleSync_r || !battSync_r || (state_r != SEQ_OFF && state_r != SEQ_PRESS);
  // boot time counts from the toggle low seen with battery present
  assign bootClear  = (state_r == SEQ_OFF) && (toggleSync_r || !battSync_r);
  assign pressLong  = pressCnt >= PRESS_LIM;

  sync_counter #(.WIDTH(CNT_W)) u_pressCnt (
    .mclk  (mclk),
    .rst_b (rst_b),
    .clear (pressClear),
    .count (pressCnt)
  );

  sync_counter #(.WIDTH(CNT_W)) u_bootCnt (
    .mclk  (mclk),
    .rst_b (rst_b),
    .clear (bootClear),
    .count (bootCnt)
  );

  // resets to the absent level so no false battery edge follows reset
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      battPrev_r <= 1'b0;
    end else begin
      battPrev_r <= battSync_r;
    end
  end

  // only a toggle already low as battery arrives is a tied start; a plain press keeps its full low time
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      tiedLow_r <= 1'b0;
    end else if (!battSync_r) begin
      tiedLow_r <= 1'b0;
    end else if (state_r == SEQ_OFF && battSync_r && !battPrev_r && !toggleSync_r) begin
      tiedLow_r <= 1'b1;
    end
  end

  // ==========================================================================
  // sequence state
  // ==========================================================================
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SEQ_OFF: begin
        if (battSync_r && !toggleSync_r) begin
          state_nxt = SEQ_PRESS;
        end
      end
      SEQ_PRESS: begin
        // short presses are ignored; the start needs the full low time or a tied pin
        if (tiedLow_r) begin
          state_nxt = SEQ_BOOT;
        end else if (toggleSync_r) begin
          state_nxt = pressLong ? SEQ_BOOT : SEQ_OFF;
        end
      end
      SEQ_BOOT: begin
        if (bootCnt >= MONITOR_LIM) begin
          state_nxt = SEQ_PADS_DONE;
        end
      end
      SEQ_PADS_DONE: begin
        if (bootCnt >= READY_LIM) begin
          state_nxt = SEQ_ACTIVE;
        end
      end
      SEQ_ACTIVE: begin
        state_nxt = SEQ_ACTIVE;
      end
      default: begin
        state_nxt = SEQ_OFF;
      end
    endcase
    // losing the battery drops everything at once
    if (!battSync_r) begin
      state_nxt = SEQ_OFF;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= SEQ_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  logic monitor_r;
  logic ready_r;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      monitor_r <= 1'b0;
      ready_r   <= 1'b0;
    end else begin
      monitor_r <= (state_nxt == SEQ_PADS_DONE) || (state_nxt == SEQ_ACTIVE);
      ready_r   <= (state_nxt == SEQ_ACTIVE);
    end
  end

  assign powerMonitor = monitor_r;
  assign auxSupplyOut = monitor_r;
  // access stays refused through the whole boot
  assign hostAccessOk = ready_r;

  // pin eight carries ready unless reassigned to plain output
  assign sharedPin8Out = (sharedPinFn == PIN_FN_READY) ? ready_r : sharedPinGpioOut;
  assign sharedPin8Oe  = monitor_r || (sharedPinFn == PIN_FN_READY);

  assign status = '{softwareReady: ready_r,
                    powerMonitor:  monitor_r,
                    auxSupplyOut:  monitor_r,
                    booting:       (state_r == SEQ_BOOT) || (state_r == SEQ_PADS_DONE)};

  // ==========================================================================
  // checks
  // ==========================================================================
  AST_READY_AFTER_MIN: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(ready_r) |-> bootCnt >= OPER_LIM)
    else $error("ready rose too early");

  AST_READY_NEEDS_MON: assert property (@(posedge mclk) disable iff (!rst_b)
    ready_r |-> monitor_r)
    else $error("ready without power monitor");

  AST_MON_TIME: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(monitor_r) |-> bootCnt >= MONITOR_LIM && bootCnt < READY_LIM)
    else $error("power monitor rose at wrong time");

  AST_NO_ACCESS_BOOT: assert property (@(posedge mclk) disable iff (!rst_b)
    status.booting |-> !hostAccessOk)
    else $error("host access during boot");

  AST_PIN8_READY: assert property (@(posedge mclk) disable iff (!rst_b)
    sharedPinFn == PIN_FN_READY |-> sharedPin8Out == ready_r && sharedPin8Oe)
    else $error("pin eight not carrying ready");

  AST_SHORT_PRESS: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == SEQ_PRESS && toggleSync_r && !pressLong && !tiedLow_r |=> state_r == SEQ_OFF)
    else $error("short press started boot");

  AST_TIED_START: assert property (@(posedge mclk) disable iff (!rst_b)
    state_r == SEQ_PRESS && tiedLow_r && battSync_r |=> state_r == SEQ_BOOT)
    else $error("tied-low start not taken");

  AST_BATT_LOSS: assert property (@(posedge mclk) disable iff (!rst_b)
    !battSync_r |=> ##1 !ready_r && !monitor_r)
    else $error("outputs stayed up without battery");

  AST_PULLUP: assert property (@(posedge mclk) disable iff (!rst_b)
    powerTogglePullUp)
    else $error("pull-up released");

endmodule

`default_nettype wire

// ==== shared/power_seq_pkg.sv ====
// constants and carrier types for the module power-on sequencer
// assumes a single 100 MHz clock domain and seconds-scale timing
`default_nettype none

package power_seq_pkg;

  // ==========================================================================
  // clock and timing
  // ==========================================================================
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned PRESS_MIN_MS    = 1000;
  localparam int unsigned OPER_MIN_S      = 20;
  localparam int unsigned MONITOR_TYP_S   = 21;
  localparam int unsigned READY_TYP_S     = 28;
  localparam longint unsigned PRESS_CYC   = (longint'(CLK_HZ) * PRESS_MIN_MS + 999) / 1000;
  localparam longint unsigned MONITOR_CYC = longint'(CLK_HZ) * MONITOR_TYP_S;
  localparam longint unsigned READY_CYC   = longint'(CLK_HZ) * READY_TYP_S;
  localparam int unsigned CNT_W           = 32;

  // ==========================================================================
  // shared pin eight and its functions
  // ==========================================================================
  localparam int unsigned SHARED_PIN_IDX  = 8;
  localparam logic        PIN_FN_READY    = 1'b0;
  localparam logic        PIN_FN_GPIO     = 1'b1;
  localparam logic        PIN_FN_RESET    = PIN_FN_READY;

  typedef enum {
    SEQ_OFF,
    SEQ_PRESS,
    SEQ_BOOT,
    SEQ_PADS_DONE,
    SEQ_ACTIVE
  } seqState_t;

  // status carried out of the sequencer
  typedef struct packed {
    logic softwareReady;
    logic powerMonitor;
    logic auxSupplyOut;
    logic booting;
  } seqStatus_t;

endpackage

`default_nettype wire

// ==== verilog/sync_counter.sv ====
// saturating up-counter with synchronous clear
// assumes the caller holds clear while the count is not wanted
`default_nettype none

module sync_counter
  import power_seq_pkg::*;
#(
  parameter int unsigned WIDTH = CNT_W
) (
  input  wire logic             mclk,
  input  wire logic             rst_b,
  input  wire logic             clear,
  output logic [WIDTH-1:0]      count
);

  // saturate so a stuck input can never wrap the count back under a threshold
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (count != {WIDTH{1'b1}}) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule

`default_nettype wire

// ==== test/host_power_model.sv ====
// host side model: open-collector driver of the power toggle pin
// assumes the bench resolves the pin from pullLow and the internal pull-up
`default_nettype none

module host_power_model (
  input  wire logic mclk,
  input  wire logic softwareReady,
  output logic      pullLow
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // toggle driving
  // ==========================================================================
  // never drives high, so the pin is low or left to the pull-up
  initial pullLow = 1'b0;

  task automatic press(input int lowCycles);
    pullLow <= 1'b1;
    repeat (lowCycles) @(posedge mclk); // own counter times the pulse
    pullLow <= 1'b0;
  endtask

  task automatic holdLow(input logic low);
    pullLow <= low;
  endtask

  // bounded start-up wait; commands only after ready is seen high
  task automatic waitReady(input int limit, output bit ok);
    ok = 1'b0;
    repeat (limit) begin
      @(posedge mclk);
      if (softwareReady === 1'b1 && !ok) ok = 1'b1;
    end
  endtask
endmodule

`default_nettype wire

// ==== test/module_power_on_sequencer_tb.sv ====
// testbench for the power-on sequencer with a host model on the toggle pin
// assumes shortened boot counts; times are checked in clock cycles
`default_nettype none

module module_power_on_sequencer_tb;
  import power_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PRESS = 10;
  localparam int MON   = 40;
  localparam int RDY   = 60;

  typedef struct {bit isReady; int start; int lo; int hi;} note_t;

  logic       mclk = 1'b0, rst_b, batteryPresent, sharedPinFn, sharedPinGpioOut;
  logic       pullLow, pullUp, sharedPin8Out, sharedPin8Oe, powerMonitor, auxSupplyOut, hostAccessOk;
  seqStatus_t status;
  wire logic  toggleWire = pullLow ? 1'b0 : pullUp;
  int         cyc = 0, fail_count = 0, checks_done = 0;
  bit         monPrev = 1'b0, rdyPrev = 1'b0, ok;
  logic       v;
  note_t      notes[$];

  always #5 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  module_power_on_sequencer #(.PRESS_CYCLES(PRESS), .MONITOR_CYCLES(MON), .READY_CYCLES(RDY)) u_dut (
    .mclk(mclk), .rst_b(rst_b), .batteryPresent(batteryPresent), .powerToggle_n(toggleWire),
    .powerTogglePullUp(pullUp), .sharedPinFn(sharedPinFn), .sharedPinGpioOut(sharedPinGpioOut),
    .sharedPin8Out(sharedPin8Out), .sharedPin8Oe(sharedPin8Oe), .powerMonitor(powerMonitor),
    .auxSupplyOut(auxSupplyOut), .hostAccessOk(hostAccessOk), .status(status));

  host_power_model u_host (.mclk(mclk), .softwareReady(hostAccessOk), .pullLow(pullLow));

  // ==========================================================================
  // compares and closing
  // ==========================================================================
  task automatic check_bit(input logic got, input logic exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask

  task automatic check_time(input int got, input int lo, input int hi, input string msg);
    checks_done++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("MISMATCH t=%0t %s took %0d", $time, msg, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ==========================================================================
  // watcher: each rise of power monitor or ready takes the oldest note
  // ==========================================================================
  task automatic takeNote(input bit isReady);
    note_t n;
    if (notes.size() == 0) begin
      check_bit(1'b1, 1'b0, "unexpected rise");
      return;
    end
    n = notes.pop_front();
    check_bit(isReady, n.isReady, "rise order");
    check_time(cyc - n.start, n.lo, n.hi, "rise time");
    if (!isReady) check_bit(hostAccessOk, 1'b0, "ready with monitor");
    if (!isReady) check_bit(auxSupplyOut, 1'b1, "aux supply");
    if (isReady) check_bit(sharedPin8Out, 1'b1, "pin eight ready");
    if (isReady) check_bit(status.softwareReady, 1'b1, "status ready");
    check_bit(status.booting, !isReady, "status booting");
    check_bit(status.powerMonitor && status.auxSupplyOut, 1'b1, "status monitor");
  endtask

  always @(posedge mclk) begin
    if (powerMonitor === 1'b1 && !monPrev) takeNote(1'b0);
    if (hostAccessOk === 1'b1 && !rdyPrev) takeNote(1'b1);
    monPrev <= (powerMonitor === 1'b1);
    rdyPrev <= (hostAccessOk === 1'b1);
  end

  // ==========================================================================
  // tests
  // ==========================================================================
  task automatic expectBoot();
    notes.push_back('{1'b0, cyc, MON, MON + 8});
    notes.push_back('{1'b1, cyc, RDY, RDY + 8});
  endtask

  initial begin
    // whole run is a few hundred cycles
    repeat (3000) @(posedge mclk);
    fail_count++;
    test_done();
  end

  initial begin
    void'($urandom(87));
    rst_b = 1'b0;
    batteryPresent = 1'b0;
    sharedPinFn = PIN_FN_READY;
    sharedPinGpioOut = 1'b0;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    batteryPresent <= 1'b1;
    repeat (4) @(posedge mclk);
    // a press shorter than the minimum must be refused
    sharedPinFn <= PIN_FN_GPIO;
    u_host.press(1 + int'($urandom % (PRESS - 1)));
    repeat (6) @(posedge mclk);
    check_bit(status.booting, 1'b0, "short press refused");
    check_bit(sharedPin8Oe, 1'b0, "pin eight idle while off");
    sharedPinFn <= PIN_FN_READY;
    expectBoot();
    u_host.press(PRESS + int'($urandom % 8));
    u_host.waitReady(RDY + 20, ok);
    check_bit(ok, 1'b1, "normal boot ready");
    for (int i = 0; i < 6; i++) begin
      v = 1'(($urandom % 2));
      sharedPinFn <= PIN_FN_GPIO;
      sharedPinGpioOut <= v;
      repeat (2) @(posedge mclk);
      check_bit(sharedPin8Out, v, "pin eight gpio");
      check_bit(sharedPin8Oe, 1'b1, "pin eight enable");
    end
    sharedPinFn <= PIN_FN_READY;
    repeat (2) @(posedge mclk);
    check_bit(sharedPin8Out, 1'b1, "pin eight back to ready");
    batteryPresent <= 1'b0;
    repeat (6) @(posedge mclk);
    check_bit(powerMonitor, 1'b0, "monitor after battery loss");
    check_bit(hostAccessOk, 1'b0, "ready after battery loss");
    $display("test normal boot done");
    // toggle tied to ground before battery arrives
    u_host.holdLow(1'b1);
    repeat (4) @(posedge mclk);
    expectBoot();
    batteryPresent <= 1'b1;
    u_host.waitReady(RDY + 20, ok);
    check_bit(ok, 1'b1, "tied low boot ready");
    u_host.holdLow(1'b0);
    batteryPresent <= 1'b0;
    repeat (6) @(posedge mclk);
    $display("test tied low done");
    // reset in mid boot must leave nothing running
    batteryPresent <= 1'b1;
    repeat (4) @(posedge mclk);
    u_host.press(PRESS + 2);
    repeat (10) @(posedge mclk);
    rst_b <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (RDY + 20) @(posedge mclk);
    check_bit(powerMonitor, 1'b0, "no boot after reset");
    check_bit(hostAccessOk, 1'b0, "no ready after reset");
    check_bit(1'(notes.size() == 0), 1'b1, "notes left over");
    $display("test reset in boot done");
    test_done();
  end
endmodule

`default_nettype wire
